// *** design/gpic_consts.vh ***
// gpic_consts.vh: offsets, reset values and field position constants
// assumes: included by the gpio port design files, definitions only
`ifndef GPIC_CONSTS_VH
`define GPIC_CONSTS_VH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define GPIC_OFF_DATA      12'h000
`define GPIC_OFF_DIR       12'h400
`define GPIC_OFF_SENSE     12'h404
`define GPIC_OFF_BOTH      12'h408
`define GPIC_OFF_EVENT     12'h40c
`define GPIC_OFF_MASK      12'h410
`define GPIC_OFF_RAW       12'h414
`define GPIC_OFF_MIS       12'h418
`define GPIC_OFF_CLEAR     12'h41c
`define GPIC_OFF_ALTFN     12'h420
`define GPIC_OFF_DRV_LO    12'h500
`define GPIC_OFF_DRV_MID   12'h504
`define GPIC_OFF_DRV_HI    12'h508
`define GPIC_OFF_OPEN_DR   12'h50c
`define GPIC_OFF_PULL_UP   12'h510
`define GPIC_OFF_PULL_DN   12'h514
`define GPIC_OFF_SLEW      12'h518
`define GPIC_OFF_DIG_EN    12'h51c
`define GPIC_OFF_ID_BASE   12'hfd0

// ************************************************************
// reset values
// ************************************************************
`define GPIC_RST_ZERO      8'h00
`define GPIC_RST_DRV_LO    8'hff
`define GPIC_RST_PULL_UP   8'hff
`define GPIC_RST_DIG_EN    8'hff

// ************************************************************
// field positions
// ************************************************************
`define GPIC_DATA_MASK_LSB 2
`define GPIC_ADC_PIN       4

`endif

// *** design/gpic_sync.v ***
// gpic_sync.v: two flip-flop synchroniser, one per pin
// assumes: single clock, asynchronous active low reset
`timescale 1ns/10ps
module gpic_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys_in, // system clock
    input  wire             rst_n_in,   // async reset, active low
    input  wire [WIDTH-1:0] async_in,   // raw pin levels
    output wire [WIDTH-1:0] sync_out    // synchronised levels
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // first stage feeds only the second stage
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate
endmodule

// *** design/gpic_id_rom.v ***
// gpic_id_rom.v: identification words with a registered read port
// assumes: index is the word slot above the identification base
`timescale 1ns/10ps
module gpic_id_rom #(
    parameter [7:0] ID0  = 8'h5a, // arbitrary value
    parameter [7:0] ID1  = 8'h01, // arbitrary value
    parameter [7:0] ID2  = 8'h02, // arbitrary value
    parameter [7:0] ID3  = 8'h03, // arbitrary value
    parameter [7:0] CID0 = 8'h11, // arbitrary value
    parameter [7:0] CID1 = 8'h22, // arbitrary value
    parameter [7:0] CID2 = 8'h33, // arbitrary value
    parameter [7:0] CID3 = 8'h44  // arbitrary value
) (
    input  wire       clk_sys_in, // system clock
    input  wire       rst_n_in,   // async reset, active low
    input  wire [3:0] index_in,   // word slot from 0xfd0
    output reg  [7:0] data_out    // registered word
);
    reg [7:0] word_d;

    always @* begin
        case (index_in)
            4'h4:    word_d = ID0;
            4'h5:    word_d = ID1;
            4'h6:    word_d = ID2;
            4'h7:    word_d = ID3;
            4'h8:    word_d = CID0;
            4'h9:    word_d = CID1;
            4'ha:    word_d = CID2;
            4'hb:    word_d = CID3;
            default: word_d = 8'h00;
        endcase
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= 8'h00;
        end else begin
            data_out <= word_d;
        end
    end
endmodule

// *** design/gpic_port.v ***
// gpic_port.v: one 8-bit general-purpose port with interrupt control
// assumes: pins synchronous-free inputs, simple strobe register port,
// read data valid the cycle after the read strobe
//
// Summary of operation
// - all pin interrupt conditions OR into one port interrupt output
// - latched edge event stays pending until software clears it
// - sense, both-edges and event bits choose the trigger per pin
// - mask bit one passes a pin to the interrupt output
// - raw status sets on the condition regardless of mask
// - masked status shows only conditions the mask lets through
// - writing one to the clear register clears that pin's event
// - reprogramming triggers while unmasked may raise spurious events
// - unmasked adc pin event also pulses the adc trigger
// - alternate-function bit hands the pin to its peripheral
// - reset leaves pins as inputs except debug pins in alt function
// - pad registers select drive, open drain, pulls, slew, input
// - read-only identification words identify the block
// - interrupt registers sit at 0x404 to 0x41c, reset zero
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "gpic_consts.vh"
module gpic_port #(
    parameter       WIDTH      = 8,
    parameter [7:0] ALT_RESET  = 8'h00, // debug pins in alt function
    parameter       HAS_ADC    = 0      // 1 on the port with adc pin
) (
    input  wire             clk_sys_in,      // system clock
    input  wire             rst_n_in,        // async reset, active low
    input  wire [11:0]      reg_addr_in,     // byte address
    input  wire [31:0]      reg_wdata_in,    // write data
    input  wire             reg_wr_in,       // write strobe
    input  wire             reg_rd_in,       // read strobe
    output reg  [31:0]      reg_rdata_out,   // read data, next cycle
    input  wire [WIDTH-1:0] pin_in,          // pad input levels
    output wire [WIDTH-1:0] pin_out,         // pad output levels
    output wire [WIDTH-1:0] pin_oe_out,      // pad output enables
    input  wire [WIDTH-1:0] periph_out_in,   // peripheral drive level
    input  wire [WIDTH-1:0] periph_oe_in,    // peripheral drive enable
    output wire [WIDTH-1:0] periph_in_out,   // pin level to peripheral
    output wire             port_irq_out,    // port interrupt, high
    output reg              adc_trigger_out, // adc trigger pulse
    output wire [WIDTH-1:0] drive_low_out,   // 2 mA select
    output wire [WIDTH-1:0] drive_mid_out,   // 4 mA select
    output wire [WIDTH-1:0] drive_high_out,  // 8 mA select
    output wire [WIDTH-1:0] open_drain_out,  // open drain select
    output wire [WIDTH-1:0] pull_up_out,     // pull-up select
    output wire [WIDTH-1:0] pull_down_out,   // pull-down select
    output wire [WIDTH-1:0] slew_ctrl_out,   // slew control select
    output wire [WIDTH-1:0] dig_in_en_out    // digital input enable
);
    // ************************************************************
    // registers
    // ************************************************************
    reg  [WIDTH-1:0] pin_data_reg_q;
    reg  [WIDTH-1:0] direction_reg_q;
    reg  [WIDTH-1:0] int_sense_select_q;
    reg  [WIDTH-1:0] both_edges_select_q;
    reg  [WIDTH-1:0] event_polarity_select_q;
    reg  [WIDTH-1:0] int_mask_q;
    reg  [WIDTH-1:0] edge_latch_q;
    reg  [WIDTH-1:0] alt_function_select_q;
    reg  [WIDTH-1:0] drive_low_select_q;
    reg  [WIDTH-1:0] drive_mid_select_q;
    reg  [WIDTH-1:0] drive_high_select_q;
    reg  [WIDTH-1:0] open_drain_select_q;
    reg  [WIDTH-1:0] pull_up_select_q;
    reg  [WIDTH-1:0] pull_down_select_q;
    reg  [WIDTH-1:0] slew_control_select_q;
    reg  [WIDTH-1:0] digital_input_enable_q;
    reg  [WIDTH-1:0] prev_q;
    reg              id_sel_q;
    reg  [WIDTH-1:0] edge_d;
    reg  [WIDTH-1:0] raw_int_status;
    reg  [WIDTH-1:0] level_hit;
    reg  [WIDTH-1:0] rdata_d;
    reg              id_sel_d;
    wire [WIDTH-1:0] sync_pins;
    wire [WIDTH-1:0] in_gated;
    wire [WIDTH-1:0] rise;
    wire [WIDTH-1:0] fall;
    wire [WIDTH-1:0] edge_hit;
    wire [WIDTH-1:0] masked_int_status;
    wire [WIDTH-1:0] clr_bits;
    wire [WIDTH-1:0] addr_mask;
    wire [7:0]       id_word;
    wire             wr_clear;
    wire             adc_event;
    integer          k;

    // ************************************************************
    // pin input path
    // ************************************************************
    gpic_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (pin_in),
        .sync_out   (sync_pins)
    );

    // inputs with the digital enable cleared read as low
    assign in_gated = sync_pins & digital_input_enable_q;

    // ************************************************************
    // mode control and pad settings
    // ************************************************************
    // alternate function hands drive to the peripheral
    assign pin_out    = (alt_function_select_q & periph_out_in) |
                        (~alt_function_select_q & pin_data_reg_q);
    // open drain only ever drives low
    assign pin_oe_out = ((alt_function_select_q & periph_oe_in) |
                        (~alt_function_select_q & direction_reg_q)) &
                        ~(open_drain_select_q & pin_out);
    assign periph_in_out  = in_gated;
    assign drive_low_out  = drive_low_select_q;
    assign drive_mid_out  = drive_mid_select_q;
    assign drive_high_out = drive_high_select_q;
    assign open_drain_out = open_drain_select_q;
    assign pull_up_out    = pull_up_select_q;
    assign pull_down_out  = pull_down_select_q;
    assign slew_ctrl_out  = slew_control_select_q;
    assign dig_in_en_out  = digital_input_enable_q;

    // ************************************************************
    // interrupt detection
    // ************************************************************
    assign rise = in_gated & ~prev_q;
    assign fall = ~in_gated & prev_q;
    assign edge_hit = (both_edges_select_q & (rise | fall)) |
                      (~both_edges_select_q & event_polarity_select_q
                       & rise) |
                      (~both_edges_select_q & ~event_polarity_select_q
                       & fall);
    assign wr_clear = reg_wr_in && (reg_addr_in == `GPIC_OFF_CLEAR);
    assign clr_bits = wr_clear ? reg_wdata_in[WIDTH-1:0]
                               : {WIDTH{1'b0}};

    always @* begin
        for (k = 0; k < WIDTH; k = k + 1) begin
            level_hit[k] = ~(in_gated[k] ^ event_polarity_select_q[k]);
            // a new edge in the clear cycle wins over the clear
            edge_d[k] = (edge_latch_q[k] & ~clr_bits[k]) |
                        (~int_sense_select_q[k] & edge_hit[k]);
            raw_int_status[k] = int_sense_select_q[k] ? level_hit[k]
                                : edge_latch_q[k];
        end
    end

    assign masked_int_status = raw_int_status & int_mask_q;
    assign port_irq_out = |masked_int_status;

    // only a fresh event on the adc pin fires the trigger, not a hold
    generate
        if (HAS_ADC != 0) begin : g_adc
            assign adc_event = int_mask_q[`GPIC_ADC_PIN] &
                (int_sense_select_q[`GPIC_ADC_PIN] ?
                 (level_hit[`GPIC_ADC_PIN] &
                  (in_gated[`GPIC_ADC_PIN] ^ prev_q[`GPIC_ADC_PIN]))
                 : edge_hit[`GPIC_ADC_PIN]);
        end else begin : g_no_adc
            assign adc_event = 1'b0;
        end
    endgenerate

    // ************************************************************
    // register writes
    // ************************************************************
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_data_reg_q          <= {WIDTH{1'b0}};
            direction_reg_q         <= {WIDTH{1'b0}};
            int_sense_select_q      <= {WIDTH{1'b0}};
            both_edges_select_q     <= {WIDTH{1'b0}};
            event_polarity_select_q <= {WIDTH{1'b0}};
            int_mask_q              <= {WIDTH{1'b0}};
            edge_latch_q            <= {WIDTH{1'b0}};
            alt_function_select_q   <= ALT_RESET;
            drive_low_select_q      <= `GPIC_RST_DRV_LO;
            drive_mid_select_q      <= `GPIC_RST_ZERO;
            drive_high_select_q     <= `GPIC_RST_ZERO;
            open_drain_select_q     <= `GPIC_RST_ZERO;
            pull_up_select_q        <= `GPIC_RST_PULL_UP;
            pull_down_select_q      <= `GPIC_RST_ZERO;
            slew_control_select_q   <= `GPIC_RST_ZERO;
            digital_input_enable_q  <= `GPIC_RST_DIG_EN;
            prev_q                  <= {WIDTH{1'b0}};
            adc_trigger_out         <= 1'b0;
        end else begin
            prev_q          <= in_gated;
            edge_latch_q    <= edge_d;
            adc_trigger_out <= adc_event;
            if (reg_wr_in && reg_addr_in[11:10] == 2'b00) begin
                // address bits pick which data bits the write touches
                pin_data_reg_q <= (pin_data_reg_q & ~addr_mask) |
                                  (reg_wdata_in[WIDTH-1:0] & addr_mask);
            end
            if (reg_wr_in) begin
                // trigger changes are not filtered; see mask advice
                case (reg_addr_in)
                    `GPIC_OFF_DIR:     direction_reg_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_SENSE:   int_sense_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_BOTH:    both_edges_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_EVENT:   event_polarity_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_MASK:    int_mask_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_ALTFN:   alt_function_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_DRV_LO:  drive_low_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_DRV_MID: drive_mid_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_DRV_HI:  drive_high_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_OPEN_DR: open_drain_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_PULL_UP: pull_up_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_PULL_DN: pull_down_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_SLEW:    slew_control_select_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    `GPIC_OFF_DIG_EN:  digital_input_enable_q <=
                                        reg_wdata_in[WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    assign addr_mask = reg_addr_in[`GPIC_DATA_MASK_LSB +: WIDTH];

    // ************************************************************
    // register reads
    // ************************************************************
    gpic_id_rom u_id (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .index_in   (reg_addr_in[5:2] - 4'h4),
        .data_out   (id_word)
    );

    always @* begin
        rdata_d  = {WIDTH{1'b0}};
        id_sel_d = 1'b0;
        if (reg_addr_in[11:10] == 2'b00) begin
            // outputs read back the latch, inputs the pin
            rdata_d = ((direction_reg_q & pin_data_reg_q) |
                       (~direction_reg_q & in_gated)) & addr_mask;
        end else if (reg_addr_in >= `GPIC_OFF_ID_BASE) begin
            id_sel_d = 1'b1;
        end else begin
            case (reg_addr_in)
                `GPIC_OFF_DIR:     rdata_d = direction_reg_q;
                `GPIC_OFF_SENSE:   rdata_d = int_sense_select_q;
                `GPIC_OFF_BOTH:    rdata_d = both_edges_select_q;
                `GPIC_OFF_EVENT:   rdata_d = event_polarity_select_q;
                `GPIC_OFF_MASK:    rdata_d = int_mask_q;
                `GPIC_OFF_RAW:     rdata_d = raw_int_status;
                `GPIC_OFF_MIS:     rdata_d = masked_int_status;
                `GPIC_OFF_ALTFN:   rdata_d = alt_function_select_q;
                `GPIC_OFF_DRV_LO:  rdata_d = drive_low_select_q;
                `GPIC_OFF_DRV_MID: rdata_d = drive_mid_select_q;
                `GPIC_OFF_DRV_HI:  rdata_d = drive_high_select_q;
                `GPIC_OFF_OPEN_DR: rdata_d = open_drain_select_q;
                `GPIC_OFF_PULL_UP: rdata_d = pull_up_select_q;
                `GPIC_OFF_PULL_DN: rdata_d = pull_down_select_q;
                `GPIC_OFF_SLEW:    rdata_d = slew_control_select_q;
                `GPIC_OFF_DIG_EN:  rdata_d = digital_input_enable_q;
                default:           rdata_d = {WIDTH{1'b0}};
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    reg [WIDTH-1:0] rdata_q;
    reg             rd_q;
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q  <= {WIDTH{1'b0}};
            rd_q     <= 1'b0;
            id_sel_q <= 1'b0;
        end else begin
            rdata_q  <= reg_rd_in ? rdata_d : {WIDTH{1'b0}};
            rd_q     <= reg_rd_in;
            id_sel_q <= reg_rd_in & id_sel_d;
        end
    end

    always @* begin
        reg_rdata_out = 32'h0000_0000;
        if (rd_q) begin
            if (id_sel_q) begin
                reg_rdata_out[7:0] = id_word;
            end else begin
                reg_rdata_out[WIDTH-1:0] = rdata_q;
            end
        end
    end
endmodule

// *** verif/gpic_pin_env.sv ***
// gpic_pin_env.sv: pad levels and peripheral drive at the far side
// assumes: the bench calls set_pins just after a clock edge
`timescale 1ns/10ps
module gpic_pin_env (
    input  wire logic       clk_sys_in,       // system clock
    output logic      [7:0] pad_level_out,    // levels seen at the pads
    output logic      [7:0] periph_level_out, // peripheral drive level
    output logic      [7:0] periph_en_out     // peripheral drive enable
);
    logic [7:0] level_q = 8'h00;
    logic [7:0] lfsr_q  = 8'h5b;

    // a level holds until the next call
    task automatic set_pins(input logic [7:0] v);
        level_q <= v;
    endtask

    // changes each cycle so a stale copy cannot match
    always @(posedge clk_sys_in)
        lfsr_q <= {lfsr_q[6:0], ^(lfsr_q & 8'hb8)};

    assign pad_level_out    = level_q;
    assign periph_level_out = lfsr_q;
    assign periph_en_out    = ~lfsr_q;
endmodule

// *** verif/gpic_port_properties.sv ***
// gpic_port_properties.sv: port-level checks for one gpio port
// assumes: bound to gpic_port, pin 7 reset into alt function
`timescale 1ns/10ps
`include "gpic_consts.vh"
module gpic_port_checker (
    input logic        clk_sys_in,     // system clock
    input logic        rst_n_in,       // async reset, active low
    input logic [11:0] reg_addr_in,    // byte address
    input logic [31:0] reg_wdata_in,   // write data
    input logic        reg_wr_in,      // write strobe
    input logic        reg_rd_in,      // read strobe
    input logic [31:0] reg_rdata_out,  // read data
    input logic [7:0]  pin_in,         // pad levels
    input logic [7:0]  pin_oe_out,     // pad enables
    input logic [7:0]  periph_oe_in,   // peripheral enables
    input logic [7:0]  periph_in_out,  // level to peripheral
    input logic        port_irq_out,   // port interrupt
    input logic [7:0]  drive_low_out,  // 2 mA select
    input logic [7:0]  open_drain_out, // open drain select
    input logic [7:0]  pull_up_out,    // pull-up select
    input logic [7:0]  pull_down_out,  // pull-down select
    input logic [7:0]  dig_in_en_out   // digital input enable
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // edges since release; sync needs two
    logic [1:0] age_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
        if (!rst_n_in)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;

    a_rd_idle_zero: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("stray read data");
    a_unmapped_zero: assert property (
        reg_rd_in && reg_addr_in == 12'h600 |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_mis_irq_tie: assert property (
        reg_rd_in && reg_addr_in == `GPIC_OFF_MIS
        |=> (|reg_rdata_out[7:0]) == $past(port_irq_out))
        else $error("status and irq differ");
    a_sync_path: assert property (
        age_q == 2'h3 |-> periph_in_out == ($past(pin_in, 2) & dig_in_en_out))
        else $error("sync delay wrong");
    a_reset_pads: assert property (
        age_q == 2'h0 |-> drive_low_out == 8'hff && pull_up_out == 8'hff
        && dig_in_en_out == 8'hff && pull_down_out == 8'h00)
        else $error("pad reset wrong");
    a_reset_alt_oe: assert property (
        age_q == 2'h0 |-> pin_oe_out == {periph_oe_in[7], 7'h00})
        else $error("enable reset wrong");
    a_od_write_only: assert property (
        $changed(open_drain_out)
        |-> $past(reg_wr_in) && $past(reg_addr_in) == `GPIC_OFF_OPEN_DR)
        else $error("stray open drain change");
    a_pullup_write: assert property (
        reg_wr_in && reg_addr_in == `GPIC_OFF_PULL_UP
        |=> pull_up_out == $past(reg_wdata_in[7:0]))
        else $error("pull-up write not taken");
endmodule

// *** verif/testbench.sv ***
// testbench.sv: self-checking bench for one gpio port with the adc pin
// assumes: pin model gpic_pin_env, checker bound below
`timescale 1ns/10ps
`include "gpic_consts.vh"
module testbench;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h000;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        rd_prev = 1'b0;
    wire  [31:0] reg_rdata_out;
    wire  [7:0]  pin_in, pin_out, pin_oe_out, p_lvl, p_en;
    wire         port_irq_out, adc_trigger_out;
    wire  [7:0][7:0] pd;
    int          failures = 0;
    int          checked = 0;
    int          adc_cnt = 0;
    logic [31:0] seed = 32'd75452;
    logic [31:0] exp_q[$];
    string       nm_q[$];
    logic [7:0]  b, bo, ev, d;
    logic [11:0] roff[10] = '{12'h404, 12'h408, 12'h40c, 12'h410, 12'h414,
                              12'h418, 12'h420, 12'h500, 12'h510, 12'h51c};
    logic [7:0]  rval[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h80, 8'hff, 8'hff, 8'hff};

    gpic_port #(.WIDTH(8), .ALT_RESET(8'h80), .HAS_ADC(1)) dut (
        .clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .pin_in, .pin_out, .pin_oe_out,
        .periph_out_in(p_lvl), .periph_oe_in(p_en), .periph_in_out(),
        .port_irq_out, .adc_trigger_out, .drive_low_out(pd[0]),
        .drive_mid_out(pd[1]), .drive_high_out(pd[2]), .open_drain_out(pd[3]),
        .pull_up_out(pd[4]), .pull_down_out(pd[5]), .slew_ctrl_out(pd[6]),
        .dig_in_en_out(pd[7]));
    gpic_pin_env env (.clk_sys_in, .pad_level_out(pin_in),
        .periph_level_out(p_lvl), .periph_en_out(p_en));

    initial forever #5 clk_sys_in = ~clk_sys_in;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(string n, logic [31:0] seen, logic [31:0] e);
        checked++;
        if (seen !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, seen);
        end
    endtask

    // strobes set once per edge, so calls may follow back to back
    task automatic acc(logic w, logic r, logic [11:0] a, logic [7:0] v,
                       logic [31:0] e, string n);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= {24'h0, v};
        if (r) begin
            exp_q.push_back(e);
            nm_q.push_back(n);
        end
        @(posedge clk_sys_in);
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] v);
        acc(1'b1, 1'b0, a, v, 32'h0, "");
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] e);
        acc(1'b0, 1'b1, a, 8'h00, {24'h0, e}, $sformatf("reg %h", a));
    endtask
    task automatic idle(int k);
        repeat (k) acc(1'b0, 1'b0, reg_addr_in, 8'h00, 32'h0, "");
    endtask
    task automatic arm(logic [7:0] s, bo, ev, p0, p1);
        wr(`GPIC_OFF_MASK, 8'h00);
        wr(`GPIC_OFF_SENSE, s);
        wr(`GPIC_OFF_BOTH, bo);
        wr(`GPIC_OFF_EVENT, ev);
        env.set_pins(p0);
        idle(4);
        wr(`GPIC_OFF_CLEAR, 8'hff);
        env.set_pins(p1);
        idle(4);
    endtask

    task automatic complete_run();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // read data stand one cycle after the strobe
    always @(posedge clk_sys_in) begin
        if (rd_prev)
            check(nm_q.pop_front(), reg_rdata_out, exp_q.pop_front());
        rd_prev = reg_rd_in;
        if (adc_trigger_out === 1'b1)
            adc_cnt++;
    end

    initial begin
        #100000;
        failures++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        idle(1);
        for (int i = 0; i < 10; i++)
            rd(roff[i], rval[i]);
        rd(12'h600, 8'h00);
        rd(`GPIC_OFF_ID_BASE, 8'h00);
        wr(`GPIC_OFF_RAW, 8'hff);
        rd(`GPIC_OFF_RAW, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'(rnd());
            wr(`GPIC_OFF_DRV_LO + 12'(4 * i), d);
            rd(`GPIC_OFF_DRV_LO + 12'(4 * i), d);
            check("pad out", pd[i], d);
        end
        wr(`GPIC_OFF_DIG_EN, 8'hff);
        wr(`GPIC_OFF_OPEN_DR, 8'h00);
        // rising, falling and both edges on pins 1, 2 and 3
        for (int m = 0; m < 3; m++) begin
            b = 8'(8'h02 << m);
            bo = (m == 2) ? b : 8'h00;
            ev = (m == 1) ? 8'h00 : b;
            arm(8'h00, bo, ev, b ^ ev, ev);
            rd(`GPIC_OFF_RAW, b);
            rd(`GPIC_OFF_MIS, 8'h00);
            wr(`GPIC_OFF_MASK, b);
            rd(`GPIC_OFF_MIS, b);
            #1 check("irq", port_irq_out, 1'b1);
            wr(`GPIC_OFF_CLEAR, b);
            rd(`GPIC_OFF_RAW, 8'h00);
            env.set_pins(b ^ ev);
            idle(4);
            rd(`GPIC_OFF_RAW, bo);
            wr(`GPIC_OFF_CLEAR, 8'h00);
            rd(`GPIC_OFF_RAW, bo);
        end
        // adc pin high level, masked then passed
        arm(8'h10, 8'h00, 8'h10, 8'h00, 8'h10);
        rd(`GPIC_OFF_RAW, 8'h10);
        env.set_pins(8'h00);
        idle(4);
        rd(`GPIC_OFF_RAW, 8'h00);
        check("adc masked", adc_cnt, 0);
        wr(`GPIC_OFF_MASK, 8'h10);
        env.set_pins(8'h10);
        idle(4);
        wr(`GPIC_OFF_CLEAR, 8'h10);
        rd(`GPIC_OFF_RAW, 8'h10);
        #1 check("irq level", port_irq_out, 1'b1);
        env.set_pins(8'h00);
        idle(4);
        rd(`GPIC_OFF_MIS, 8'h00);
        check("adc pulses", adc_cnt, 1);
        // masked data access, then alternate function
        d = 8'(rnd());
        wr(`GPIC_OFF_DIR, 8'h0f);
        wr(12'h3fc, d);
        wr(12'h00c, ~d);
        rd(12'h03c, {4'h0, d[3:2], ~d[1:0]});
        #1 check("pin out", pin_out[3:0], {d[3:2], ~d[1:0]});
        check("pin oe", pin_oe_out[3:0], 4'hf);
        wr(`GPIC_OFF_ALTFN, 8'h81);
        #1 check("alt out", pin_out[0], p_lvl[0]);
        check("alt oe", pin_oe_out[0], p_en[0]);
        rd(`GPIC_OFF_ALTFN, 8'h81);
        idle(2);
        complete_run();
    end
endmodule

bind gpic_port gpic_port_checker chk (.clk_sys_in, .rst_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pin_in,
    .pin_oe_out, .periph_oe_in, .periph_in_out, .port_irq_out,
    .drive_low_out, .open_drain_out, .pull_up_out, .pull_down_out,
    .dig_in_en_out);
